// ==== inc/ddrss_pkg.sv ====
// Shared constants and carriers for the memory-rail sleep-state sequencer
package ddrss_pkg;

    // Oscillator cycle counts and hiccup period count
    localparam int unsigned AMP_RST_CYCLES  = 2048;
    localparam int unsigned SS_CYCLES       = 2048;
    localparam int unsigned POWER_OK_DLY_CYCLES = 2048;
    localparam int unsigned HICCUP_PERIODS  = 3;

    // Ramp and counter width, enough for 2048 cycles
    localparam int unsigned CNT_W = 11;
    localparam int unsigned HIC_W = 2;

    // Reset values of synchroniser stages and outputs, and the full reference level
    localparam logic [4:0] SYNC_RST     = 5'h00;
    localparam logic [4:0] RAIL_EN_RST  = 5'h00;
    localparam logic [10:0] LEVEL_RST   = 11'h000;
    localparam logic [10:0] LEVEL_FULL  = 11'h7FF;

    // Asynchronous chipset and supply monitor levels
    typedef struct packed {
        logic suspend_to_ram_req_n;
        logic soft_off_req_n;
        logic standby_bias_supply_ok;
        logic main_12v_supply_ok;
        logic backfeed_switch_ctl_tripped;
    } ddrss_async_in_t;

    // Fault comparator outputs, synchronous to the oscillator clock
    typedef struct packed {
        logic overcurrent;
        logic core_feedback_uv;
        logic core_feedback_ov;
        logic aux_ldo_feedback_uv;
        logic aux_ldo_feedback_ov;
    } ddrss_fault_t;

    // Regulator enables
    typedef struct packed {
        logic switcher;
        logic standby_ldo;
        logic termination_rail;
        logic aux_ldo;
        logic amp_reset;
    } ddrss_rail_en_t;

endpackage : ddrss_pkg

// ==== hdl/ddrss_seq.sv ====
// Sleep-state sequencer: decode, soft-start, protection and power-good
//
// Operation
// - S4/S5 turns every regulator off
// - Termination regulator only in S0/S1, off in S3
// - S3 uses standby regulator, switcher off
// - Switcher off until backfeed switch trips
// - Power-good low when any rail out of regulation
// - Power-good low outside S0/S1/S2
// - Soft-start only with bias and 12V valid
// - Cold start leaves off when both requests high; counter held at zero until bias, 12V and trip
// - Ignore state changes until S0 reached after off
// - Start needs bias, 12V and backfeed trip
// - Hold error amplifier reset 2048 cycles
// - Then run 2048-cycle digital soft-start ramp
// - References follow the soft-start ramp value
// - Overcurrent during the ramp or once on restarts the soft-start sequence; S3 exit ignores it
// - Core feedback gives undervoltage and overvoltage faults
// - Aux feedback gives undervoltage and overvoltage faults
// - S0 to S3 pulls switch low, rails off
// - Power-good enabled 2048 cycles after leaving S3
// - Undervoltage: three idle periods, then soft-start again
// - Overvoltage latches off until reset, bias loss or off-request toggle
module ddrss_seq #(
    parameter int unsigned AMP_CYCLES = ddrss_pkg::AMP_RST_CYCLES,
    parameter int unsigned RAMP_CYCLES = ddrss_pkg::SS_CYCLES,
    parameter int unsigned PG_CYCLES  = ddrss_pkg::POWER_OK_DLY_CYCLES
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire ddrss_pkg::ddrss_async_in_t async_in_i,
    input  wire ddrss_pkg::ddrss_fault_t  fault_i,
    input  wire logic                     termination_rail_in_reg_i,
    output ddrss_pkg::ddrss_rail_en_t     rail_en_o,
    output logic [ddrss_pkg::CNT_W-1:0]   core_ref_level_o,
    output logic [ddrss_pkg::CNT_W-1:0]   aux_ref_level_o,
    output logic                          backfeed_switch_ctl_o,
    output logic                          backfeed_switch_ctl_oe_o,
    output logic                          power_ok_out_o,
    output logic                          power_ok_out_oe_o
);
    import ddrss_pkg::*;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_WAIT_COND,
        ST_AMP_RST,
        ST_SOFTSTART,
        ST_ON,
        ST_S3,
        ST_S3_EXIT,
        ST_HICCUP,
        ST_OV_LATCH
    } ddrss_state_t;

    localparam logic [CNT_W-1:0] AMP_LAST  = CNT_W'(AMP_CYCLES - 1);
    localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(RAMP_CYCLES - 1);
    localparam logic [CNT_W-1:0] PG_LAST   = CNT_W'(PG_CYCLES - 1);
    localparam logic [HIC_W-1:0] HIC_LAST  = HIC_W'(HICCUP_PERIODS - 1);

    // Two-stage synchroniser; the first stage feeds only the second
    ddrss_async_in_t sync1_reg;
    ddrss_async_in_t sync1_next;
    ddrss_async_in_t sync2_reg;
    ddrss_async_in_t sync2_next;

    always_comb begin
        sync1_next = async_in_i;
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_reg <= ddrss_async_in_t'(SYNC_RST);
            sync2_reg <= ddrss_async_in_t'(SYNC_RST);
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // Decoded sleep state
    logic req_s0;
    logic req_s3;
    logic req_off;
    logic bias_ok;
    logic v12_ok;
    logic bf_trip;
    logic any_ov;
    logic any_uv;
    logic rails_ok;

    always_comb begin
        req_off = !sync2_reg.soft_off_req_n;
        req_s3  = sync2_reg.soft_off_req_n
                  && !sync2_reg.suspend_to_ram_req_n;
        req_s0  = sync2_reg.soft_off_req_n
                  && sync2_reg.suspend_to_ram_req_n;
        bias_ok = sync2_reg.standby_bias_supply_ok;
        v12_ok  = sync2_reg.main_12v_supply_ok;
        bf_trip = sync2_reg.backfeed_switch_ctl_tripped;
        any_ov  = fault_i.core_feedback_ov
                  || fault_i.aux_ldo_feedback_ov;
        any_uv  = fault_i.core_feedback_uv
                  || fault_i.aux_ldo_feedback_uv;
        rails_ok = !any_ov && !any_uv && termination_rail_in_reg_i;
    end

    // Sequencer state and counters
    ddrss_state_t     state_reg;
    ddrss_state_t     state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [HIC_W-1:0] hic_reg;
    logic [HIC_W-1:0] hic_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + CNT_W'(1);
        hic_next   = hic_reg;
        case (state_reg)
            ST_OFF: begin
                cnt_next = '0;
                // Leave off once both requests are high; counter stays at zero
                if (req_s0) begin
                    state_next = ST_WAIT_COND;
                end
            end
            ST_WAIT_COND: begin
                cnt_next = '0;
                // Sleep requests other than off are not acted on here
                if (bias_ok && v12_ok && bf_trip) begin
                    state_next = ST_AMP_RST;
                end
            end
            ST_AMP_RST: begin
                if (cnt_reg == AMP_LAST) begin
                    state_next = ST_SOFTSTART;
                    cnt_next   = '0;
                end
            end
            ST_SOFTSTART: begin
                if (fault_i.overcurrent) begin
                    state_next = ST_HICCUP;
                    cnt_next   = '0;
                    hic_next   = '0;
                end else if (cnt_reg == RAMP_LAST) begin
                    state_next = ST_ON;
                    cnt_next   = '0;
                end
            end
            ST_ON: begin
                cnt_next = '0;
                if (req_s3) begin
                    state_next = ST_S3;
                end else if (fault_i.overcurrent || any_uv) begin
                    state_next = ST_HICCUP;
                    hic_next   = '0;
                end
            end
            ST_S3: begin
                cnt_next = '0;
                // 12V is only needed once the switcher comes back
                if (req_s0 && v12_ok) begin
                    state_next = ST_S3_EXIT;
                end
            end
            ST_S3_EXIT: begin
                if (req_s3) begin
                    state_next = ST_S3;
                    cnt_next   = '0;
                end else if (cnt_reg == PG_LAST) begin
                    state_next = ST_ON;
                    cnt_next   = '0;
                end
            end
            ST_HICCUP: begin
                // Three idle soft-start periods before ramping again
                if (cnt_reg == RAMP_LAST) begin
                    cnt_next = '0;
                    hic_next = hic_reg + HIC_W'(1);
                    if (hic_reg == HIC_LAST) begin
                        state_next = ST_SOFTSTART;
                    end
                end
            end
            ST_OV_LATCH: begin
                cnt_next = '0;
            end
            default: begin
                state_next = ST_OFF;
                cnt_next   = '0;
            end
        endcase
        // Overvoltage wins over the case exits of a running state; 12V loss and off win over it
        if (any_ov && state_reg != ST_OFF && state_reg != ST_S3
            && state_reg != ST_WAIT_COND) begin
            state_next = ST_OV_LATCH;
            cnt_next   = '0;
        end
        // 12V loss while running drops back to waiting for start
        if (!v12_ok && (state_reg == ST_AMP_RST
            || state_reg == ST_SOFTSTART || state_reg == ST_ON
            || state_reg == ST_HICCUP || state_reg == ST_S3_EXIT)) begin
            state_next = ST_WAIT_COND;
            cnt_next   = '0;
        end
        // Off request or bias loss always wins, also clears the latch
        if (req_off || !bias_ok) begin
            state_next = ST_OFF;
            cnt_next   = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= ST_OFF;
            cnt_reg   <= '0;
            hic_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            hic_reg   <= hic_next;
        end
    end

    // Registered outputs, computed from the next state
    ddrss_rail_en_t   rail_en_reg;
    ddrss_rail_en_t   rail_en_next;
    logic [CNT_W-1:0] core_lvl_reg;
    logic [CNT_W-1:0] core_lvl_next;
    logic [CNT_W-1:0] aux_lvl_reg;
    logic [CNT_W-1:0] aux_lvl_next;
    logic             bf_oe_reg;
    logic             bf_oe_next;
    logic             pg_oe_reg;
    logic             pg_oe_next;

    always_comb begin
        rail_en_next  = ddrss_rail_en_t'(RAIL_EN_RST);
        core_lvl_next = LEVEL_RST;
        aux_lvl_next  = LEVEL_RST;
        bf_oe_next    = 1'b0;
        pg_oe_next    = 1'b1;
        case (state_next)
            ST_OFF, ST_OV_LATCH: begin
                bf_oe_next = 1'b1;
            end
            ST_AMP_RST: begin
                rail_en_next.amp_reset = 1'b1;
            end
            ST_SOFTSTART: begin
                rail_en_next.switcher         = bf_trip;
                rail_en_next.termination_rail = 1'b1;
                rail_en_next.aux_ldo          = 1'b1;
                core_lvl_next = cnt_next;
                aux_lvl_next  = cnt_next;
            end
            ST_ON: begin
                rail_en_next.switcher         = bf_trip;
                rail_en_next.termination_rail = 1'b1;
                rail_en_next.aux_ldo          = 1'b1;
                core_lvl_next = LEVEL_FULL;
                aux_lvl_next  = LEVEL_FULL;
                pg_oe_next    = !rails_ok;
            end
            ST_S3: begin
                // Standby regulator carries the core rail alone
                rail_en_next.standby_ldo = 1'b1;
                bf_oe_next = 1'b1;
            end
            ST_S3_EXIT: begin
                rail_en_next.switcher         = bf_trip;
                rail_en_next.termination_rail = 1'b1;
                rail_en_next.aux_ldo          = 1'b1;
                core_lvl_next = LEVEL_FULL;
                aux_lvl_next  = cnt_next;
            end
            default: begin
                rail_en_next = ddrss_rail_en_t'(RAIL_EN_RST);
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rail_en_reg  <= ddrss_rail_en_t'(RAIL_EN_RST);
            core_lvl_reg <= LEVEL_RST;
            aux_lvl_reg  <= LEVEL_RST;
            bf_oe_reg    <= 1'b1;
            pg_oe_reg    <= 1'b1;
        end else begin
            rail_en_reg  <= rail_en_next;
            core_lvl_reg <= core_lvl_next;
            aux_lvl_reg  <= aux_lvl_next;
            bf_oe_reg    <= bf_oe_next;
            pg_oe_reg    <= pg_oe_next;
        end
    end

    // Open-drain pins only ever pull low; the level flops stay at zero
    logic bf_lvl_reg;
    logic pg_lvl_reg;

    always_ff @(posedge clk_sys_i) begin
        bf_lvl_reg <= 1'b0;
        pg_lvl_reg <= 1'b0;
    end

    always_comb begin
        rail_en_o                = rail_en_reg;
        core_ref_level_o         = core_lvl_reg;
        aux_ref_level_o          = aux_lvl_reg;
        backfeed_switch_ctl_o    = bf_lvl_reg;
        backfeed_switch_ctl_oe_o = bf_oe_reg;
        power_ok_out_o           = pg_lvl_reg;
        power_ok_out_oe_o        = pg_oe_reg;
    end

endmodule : ddrss_seq

// ==== dv/ddrss_chipset.sv ====
// Chipset model driving the two sleep-state request levels
module ddrss_chipset (
    input  wire logic       clk_sys_i,
    input  wire logic [1:0] state_cmd_i,
    output logic            suspend_to_ram_req_n_o,
    output logic            soft_off_req_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Power-up in the off state until the bench asks for more
    initial begin
        suspend_to_ram_req_n_o = 1'b0;
        soft_off_req_n_o = 1'b0;
    end
    // Levels change once just after an edge and are then held
    always @(posedge clk_sys_i) begin
        soft_off_req_n_o <= (state_cmd_i != 2'h2);
        suspend_to_ram_req_n_o <= (state_cmd_i == 2'h0);
    end
endmodule : ddrss_chipset

// ==== dv/ddrss_seq_chk.sv ====
// Port-level assertions for the sleep-state sequencer
module ddrss_seq_chk #(
    parameter int unsigned AMP_CYCLES = 2048
) (
    input wire logic                       clk_sys_i,
    input wire logic                       rst_i,
    input wire ddrss_pkg::ddrss_async_in_t async_in_i,
    input wire ddrss_pkg::ddrss_fault_t    fault_i,
    input wire logic                       termination_rail_in_reg_i,
    input wire ddrss_pkg::ddrss_rail_en_t  rail_en_o,
    input wire logic [10:0]                core_ref_level_o,
    input wire logic [10:0]                aux_ref_level_o,
    input wire logic                       backfeed_switch_ctl_o,
    input wire logic                       backfeed_switch_ctl_oe_o,
    input wire logic                       power_ok_out_o,
    input wire logic                       power_ok_out_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ddrss_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [11:0] amp_cnt_reg;
    logic [11:0] amp_cnt_next;
    logic        go_ok;
    assign go_ok = async_in_i.standby_bias_supply_ok
        && async_in_i.main_12v_supply_ok
        && async_in_i.backfeed_switch_ctl_tripped;
    // Length of the current amplifier-reset run
    always_comb begin
        amp_cnt_next = rail_en_o.amp_reset ? amp_cnt_reg + 12'h001 : 12'h000;
    end
    always_ff @(posedge clk_sys_i) begin
        amp_cnt_reg <= rst_i ? 12'h000 : amp_cnt_next;
    end
    // Five samples cover the two synchroniser stages plus the output flop
    property p_off;
        !async_in_i.soft_off_req_n [*5] |-> rail_en_o == RAIL_EN_RST
            && power_ok_out_oe_o && backfeed_switch_ctl_oe_o;
    endproperty
    a_off: assert property (p_off)
        else $error("rails on during off request");
    property p_s3;
        rail_en_o.standby_ldo |-> !rail_en_o.switcher && !rail_en_o.aux_ldo
            && !rail_en_o.termination_rail && backfeed_switch_ctl_oe_o
            && power_ok_out_oe_o;
    endproperty
    a_s3: assert property (p_s3)
        else $error("wrong rails with standby regulator");
    property p_start;
        !go_ok [*5] |-> !rail_en_o.switcher && !rail_en_o.amp_reset;
    endproperty
    a_start: assert property (p_start)
        else $error("start without all conditions");
    property p_bias;
        !async_in_i.standby_bias_supply_ok [*5] |-> rail_en_o == RAIL_EN_RST;
    endproperty
    a_bias: assert property (p_bias)
        else $error("rails on without bias");
    property p_pg_bad;
        fault_i[3:0] != 4'h0 || !termination_rail_in_reg_i
            |=> power_ok_out_oe_o;
    endproperty
    a_pg_bad: assert property (p_pg_bad)
        else $error("power good while out of regulation");
    property p_pg_on;
        !power_ok_out_oe_o |-> rail_en_o.termination_rail
            && !rail_en_o.amp_reset && core_ref_level_o == LEVEL_FULL;
    endproperty
    a_pg_on: assert property (p_pg_on)
        else $error("power good outside running state");
    property p_amp;
        $fell(rail_en_o.amp_reset) && rail_en_o.termination_rail
            |-> amp_cnt_reg == 12'(AMP_CYCLES);
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplifier reset length wrong");
    property p_ramp;
        $fell(rail_en_o.amp_reset) && rail_en_o.termination_rail
            |-> core_ref_level_o == LEVEL_RST
            ##1 core_ref_level_o == 11'h001 && aux_ref_level_o == 11'h001;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("ramp does not follow amplifier reset");
    property p_oc;
        fault_i.overcurrent && !power_ok_out_oe_o |=> rail_en_o == RAIL_EN_RST;
    endproperty
    a_oc: assert property (p_oc)
        else $error("overcurrent did not stop rails");
    property p_ov;
        (fault_i.core_feedback_ov || fault_i.aux_ldo_feedback_ov)
            && !power_ok_out_oe_o |=> (rail_en_o == RAIL_EN_RST) [*8];
    endproperty
    a_ov: assert property (p_ov)
        else $error("overvoltage latch released");
    property p_s3_exit;
        $fell(rail_en_o.standby_ldo) && rail_en_o.termination_rail
            |-> power_ok_out_oe_o [*8];
    endproperty
    a_s3_exit: assert property (p_s3_exit)
        else $error("power good too early after sleep");
    c_amp: cover property ($rose(rail_en_o.amp_reset));
    c_s3: cover property ($rose(rail_en_o.standby_ldo));
    c_trip: cover property (!power_ok_out_oe_o ##1 rail_en_o == RAIL_EN_RST);
endmodule : ddrss_seq_chk

bind ddrss_seq ddrss_seq_chk #(.AMP_CYCLES(AMP_CYCLES)) i_ddrss_seq_chk (
    .clk_sys_i, .rst_i, .async_in_i, .fault_i, .termination_rail_in_reg_i,
    .rail_en_o, .core_ref_level_o, .aux_ref_level_o, .backfeed_switch_ctl_o,
    .backfeed_switch_ctl_oe_o, .power_ok_out_o, .power_ok_out_oe_o);

// ==== dv/ddrss_seq_tb.sv ====
// Self-checking bench for the sleep-state sequencer
module ddrss_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ddrss_pkg::*;
    // Short counts keep the run brief; expectations derive from NC
    localparam int unsigned NC = 16;
    typedef struct packed {
        logic [1:0] cmd;
        logic [2:0] ok;
        logic [7:0] dly;
        logic [4:0] rail;
        logic       pg_oe;
    } ddrss_row_t;
    logic            clk_sys_i = 1'b0;
    logic            rst_i     = 1'b1;
    logic [1:0]      cmd       = 2'h2;
    logic [2:0]      ok        = 3'h0;
    logic            term_ok   = 1'b1;
    ddrss_fault_t    fault     = 5'h00;
    logic            sus_n;
    logic            off_n;
    ddrss_async_in_t async_in;
    ddrss_rail_en_t  rail;
    logic [10:0]     core_lvl;
    logic [10:0]     aux_lvl;
    logic            bf_oe;
    logic            pg_oe;
    logic            bf_lvl;
    logic            pg_lvl;
    int              n_fail = 0;
    int              n_tests = 0;
    int              cyc_cnt = 0;
    int              cnt;
    // cmd 0 = S0, 1 = S3, 2 = off; ok = {bias, 12V, trip}
    ddrss_row_t rows [12] = '{
        {2'h0, 3'h7, 8'h3C, 5'h16, 1'h0}, {2'h1, 3'h7, 8'h08, 5'h08, 1'h1},
        {2'h0, 3'h7, 8'h08, 5'h16, 1'h1}, {2'h0, 3'h7, 8'h14, 5'h16, 1'h0},
        {2'h0, 3'h6, 8'h08, 5'h06, 1'h0}, {2'h0, 3'h5, 8'h08, 5'h00, 1'h1},
        {2'h0, 3'h7, 8'h3C, 5'h16, 1'h0}, {2'h2, 3'h7, 8'h08, 5'h00, 1'h1},
        {2'h1, 3'h7, 8'h0C, 5'h00, 1'h1}, {2'h0, 3'h7, 8'h3C, 5'h16, 1'h0},
        {2'h0, 3'h3, 8'h08, 5'h00, 1'h1}, {2'h0, 3'h7, 8'h3C, 5'h16, 1'h0}};
    assign async_in = {sus_n, off_n, ok};
    ddrss_chipset i_ddrss_chipset (.clk_sys_i(clk_sys_i), .state_cmd_i(cmd),
        .suspend_to_ram_req_n_o(sus_n), .soft_off_req_n_o(off_n));
    ddrss_seq #(.AMP_CYCLES(NC), .RAMP_CYCLES(NC), .PG_CYCLES(NC)) i_ddrss_seq (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .async_in_i(async_in),
        .fault_i(fault), .termination_rail_in_reg_i(term_ok),
        .rail_en_o(rail), .core_ref_level_o(core_lvl),
        .aux_ref_level_o(aux_lvl), .backfeed_switch_ctl_o(bf_lvl),
        .backfeed_switch_ctl_oe_o(bf_oe), .power_ok_out_o(pg_lvl),
        .power_ok_out_oe_o(pg_oe));
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc
    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        cyc(2);
        rst_i = 1'b0;
        chk({pg_oe, bf_oe, rail}, 11'h060);
        foreach (rows[i]) begin
            cmd = rows[i].cmd;
            ok = rows[i].ok;
            cyc(int'(rows[i].dly));
            chk(rail, rows[i].rail);
            chk(pg_oe, rows[i].pg_oe);
        end
        // Cold restart: measure amplifier reset, then walk the ramp
        cmd = 2'h2;
        cyc(8);
        cmd = 2'h0;
        cnt = 0;
        while (rail.amp_reset !== 1'b1 && cnt < 30) begin cyc(1); cnt++; end
        cnt = 0;
        while (rail.amp_reset === 1'b1 && cnt < 40) begin cyc(1); cnt++; end
        chk(11'(cnt), 11'(NC));
        for (int i = 0; i < NC; i++) begin
            chk(core_lvl, 11'(i));
            chk(aux_lvl, 11'(i));
            cyc(1);
        end
        chk(core_lvl, LEVEL_FULL);
        cyc(2);
        term_ok = 1'b0;
        cyc(1);
        chk(pg_oe, 11'h001);
        term_ok = 1'b1;
        cyc(2);
        chk(pg_oe, 11'h000);
        // Every fault bit in turn, starting from the running state
        for (int b = 4; b >= 0; b--) begin
            fault[b] = 1'b1;
            cyc(1);
            fault = 5'h00;
            chk(rail, 11'h000);
            if (b == 2 || b == 0) begin
                cyc(20);
                chk({bf_oe, rail}, 11'h020);
                cmd = 2'h2;
                cyc(8);
                cmd = 2'h0;
                cyc(60);
            end else begin
                cnt = 0;
                while (rail === 5'h00 && cnt < 200) begin cyc(1); cnt++; end
                chk(11'(cnt), 11'(3 * NC));
                cyc(30);
            end
            chk({pg_oe, rail}, 11'h016);
        end
        // Mid-run reset, then overcurrent during the soft-start ramp
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        chk({pg_oe, bf_oe, rail}, 11'h060);
        chk({bf_lvl, pg_lvl}, 11'h000);
        cyc(24);
        chk(core_lvl, 11'h004);
        fault.overcurrent = 1'b1;
        cyc(1);
        fault = 5'h00;
        chk(rail, 11'h000);
        stop_test();
    end
endmodule : ddrss_seq_tb
